// ### design/ccs_pkg.sv
// Package: constants and types for the charge cycle sequencer
package ccs_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
    localparam int TERM_FILTER_US = 1000;
    localparam int TERM_FILTER_TICKS = (TERM_FILTER_US + TICK_US - 1) / TICK_US;
    localparam int TIMER_WIDTH = 32;
    localparam int HOUR_TICKS = 3600 * (1000000 / TICK_US);
    localparam logic [TIMER_WIDTH-1:0] TIMER_4H_TICKS = TIMER_WIDTH'(4 * HOUR_TICKS);
    localparam logic [TIMER_WIDTH-1:0] TIMER_6H_TICKS = TIMER_WIDTH'(6 * HOUR_TICKS);
    localparam logic [TIMER_WIDTH-1:0] TIMER_8H_TICKS = TIMER_WIDTH'(8 * HOUR_TICKS);
    localparam logic [2:0] REGULATION_VOLTAGE_CODE_4V10 = 3'h1;
    localparam logic [2:0] REGULATION_VOLTAGE_CODE_4V20 = 3'h2;
    localparam logic [2:0] REGULATION_VOLTAGE_CODE_4V35 = 3'h3;
    localparam logic [2:0] REGULATION_VOLTAGE_CODE_4V40 = 3'h4;
    localparam logic [1:0] REGULATION_VOLTAGE_SEL_4V10 = 2'h0;
    localparam logic [1:0] REGULATION_VOLTAGE_SEL_4V20 = 2'h1;
    localparam logic [1:0] REGULATION_VOLTAGE_SEL_4V35 = 2'h2;
    localparam logic [1:0] REGULATION_VOLTAGE_SEL_4V40 = 2'h3;
    localparam logic [1:0] CUR_OFF = 2'h0;
    localparam logic [1:0] CUR_PRECOND = 2'h1;
    localparam logic [1:0] CUR_FAST = 2'h2;
    localparam logic [1:0] CUR_CV = 2'h3;
    localparam int SYNC_WIDTH = 12;

    typedef enum logic [2:0] {
        CCS_SHUTDOWN,
        CCS_STANDBY,
        CCS_PRECOND,
        CCS_FAST,
        CCS_CV,
        CCS_COMPLETE,
        CCS_FAULT
    } ccs_state_t;
endpackage : ccs_pkg

// ### design/ccs_flag_if.sv
// Interface: synchronised comparator flags
`timescale 1ns/1ps
interface ccs_flag_if;
    logic [ccs_pkg::SYNC_WIDTH-1:0] raw;
    logic [ccs_pkg::SYNC_WIDTH-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface : ccs_flag_if

// ### design/ccs_sync.sv
// Two-flop synchroniser for the comparator flags
`timescale 1ns/1ps
module ccs_sync (
    input wire logic core_clk,
    input wire logic nrst,
    ccs_flag_if.sync_side flags
);
    logic [ccs_pkg::SYNC_WIDTH-1:0] stage1;
    logic [ccs_pkg::SYNC_WIDTH-1:0] stage2;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= flags.raw;
            stage2 <= stage1;
        end
    end

    assign flags.sync = stage2;
endmodule : ccs_sync

// ### design/ccs_sequencer.sv
// Charge cycle sequencer: states, safety timer, termination filter, status pins
//
// Notes on behaviour
// - Timer expiry in fast charge gives fault while below recharge threshold
// - Fault holds until removal, then standby
// - Regulation voltage reached moves to constant voltage
// - Option code picks regulation voltage target
// - CV ends on termination or timer expiry
// - Full battery latches current off, complete
// - Termination must hold 1 ms first
// - Timer period fixed; disable suppresses expiry
// - Complete recharges below recharge threshold
// - Die overtemperature suspends with hysteresis
// - Battery temp out of window suspends, freezes
// - Temp back in window resumes, timer continues
// - Input current limit reduces charge current
// - Input voltage control reduces, unless strapped
// - Preconditioning commands tenth of fast current
// - Status outputs only low or released
// - Status encoding per charge state table
// - Entering fast charge resets safety timer
// - Below precondition threshold precondition, else fast
// - Enable low disables charger; must not float
`timescale 1ns/1ps
module ccs_sequencer #(
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES,
    parameter logic [ccs_pkg::TIMER_WIDTH-1:0] TIMER_TICKS = ccs_pkg::TIMER_6H_TICKS,
    parameter logic [2:0] REGULATION_VOLTAGE_OPTION = ccs_pkg::REGULATION_VOLTAGE_CODE_4V20
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic charge_enable,
    input wire logic timer_disable,
    input wire logic uvlo_ok,
    input wire logic input_above_battery,
    input wire logic battery_present,
    input wire logic battery_low,
    input wire logic vbat_at_regulation,
    input wire logic vbat_below_recharge,
    input wire logic vbat_below_precond,
    input wire logic termination_set,
    input wire logic battery_temp_hot,
    input wire logic battery_temp_cold,
    input wire logic die_over_150c,
    input wire logic die_below_140c,
    input wire logic input_current_limit_ctrl,
    input wire logic input_voltage_charge_ctrl,
    input wire logic input_voltage_ctrl_strapped,
    output logic charge_on,
    output logic [1:0] charge_level,
    output logic charge_reduce,
    output logic [1:0] regulation_voltage,
    output logic timer_fault,
    output logic [2:0] charge_state,
    output logic status_line_a_out,
    output logic status_line_a_oe,
    output logic status_line_b_out,
    output logic status_line_b_oe,
    output logic input_good_n_out,
    output logic input_good_n_oe
);
    ////////////////////////////////////////////////////////////////////////////////
    // Flag synchronisation
    ccs_flag_if flags ();
    ccs_sync u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .flags(flags)
    );
    assign flags.raw = {charge_enable, timer_disable, uvlo_ok, input_above_battery,
                        battery_present, battery_low, vbat_at_regulation, vbat_below_recharge,
                        vbat_below_precond, termination_set,
                        battery_temp_hot | battery_temp_cold, die_over_150c};
    logic en_s, tdis_s, uvlo_s, inabove_s, bat_s, low_s, reg_s, rech_s, pre_s, term_s;
    logic temp_bad_s, die_hot_s;
    assign {en_s, tdis_s, uvlo_s, inabove_s, bat_s, low_s, reg_s, rech_s, pre_s, term_s,
            temp_bad_s, die_hot_s} = flags.sync;

    // Slow-moving level; a skewed sample only delays the release by a cycle
    logic die_cool_m;
    logic die_cool_s;
    logic icl_m, icl_s, vpc_m, vpc_s, strap_m, strap_s;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            die_cool_m <= 1'b0;
            die_cool_s <= 1'b0;
            icl_m <= 1'b0;
            icl_s <= 1'b0;
            vpc_m <= 1'b0;
            vpc_s <= 1'b0;
            strap_m <= 1'b0;
            strap_s <= 1'b0;
        end else begin
            die_cool_m <= die_below_140c;
            die_cool_s <= die_cool_m;
            icl_m <= input_current_limit_ctrl;
            icl_s <= icl_m;
            vpc_m <= input_voltage_charge_ctrl;
            vpc_s <= vpc_m;
            strap_m <= input_voltage_ctrl_strapped;
            strap_s <= strap_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaled tick
    logic [23:0] pre_cnt;
    logic tick;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pre_cnt <= '0;
            tick <= 1'b0;
        end else if (pre_cnt == 24'(TICK_CYCLES - 1)) begin
            pre_cnt <= '0;
            tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 24'h000001;
            tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Suspend conditions
    logic die_hot;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            die_hot <= 1'b0;
        end else if (die_hot_s) begin
            die_hot <= 1'b1;
        end else if (die_cool_s) begin
            die_hot <= 1'b0;
        end
    end

    logic suspend;
    assign suspend = temp_bad_s | die_hot;

    logic live;
    assign live = uvlo_s & inabove_s & en_s;

    ////////////////////////////////////////////////////////////////////////////////
    // State machine
    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_state_t next_state;
    logic timer_expired;
    logic term_ok;

    always_comb begin
        next_state = state;
        unique case (state)
            ccs_pkg::CCS_SHUTDOWN: begin
                next_state = bat_s ? ccs_pkg::CCS_PRECOND : ccs_pkg::CCS_STANDBY;
            end
            ccs_pkg::CCS_STANDBY: begin
                if (bat_s) begin
                    next_state = ccs_pkg::CCS_PRECOND;
                end
            end
            ccs_pkg::CCS_PRECOND: begin
                if (!bat_s) begin
                    next_state = ccs_pkg::CCS_STANDBY;
                end else if (!pre_s && !suspend) begin
                    next_state = ccs_pkg::CCS_FAST;
                end
            end
            ccs_pkg::CCS_FAST: begin
                if (!bat_s) begin
                    next_state = ccs_pkg::CCS_STANDBY;
                end else if (timer_expired && rech_s) begin
                    next_state = ccs_pkg::CCS_FAULT;
                end else if (reg_s && !suspend) begin
                    next_state = ccs_pkg::CCS_CV;
                end else if (pre_s) begin
                    next_state = ccs_pkg::CCS_PRECOND;
                end
            end
            ccs_pkg::CCS_CV: begin
                if (!bat_s) begin
                    next_state = ccs_pkg::CCS_STANDBY;
                end else if (term_ok || timer_expired) begin
                    next_state = ccs_pkg::CCS_COMPLETE;
                end
            end
            ccs_pkg::CCS_COMPLETE: begin
                if (!bat_s) begin
                    next_state = ccs_pkg::CCS_STANDBY;
                end else if (rech_s) begin
                    next_state = ccs_pkg::CCS_PRECOND;
                end
            end
            ccs_pkg::CCS_FAULT: begin
                if (!bat_s) begin
                    next_state = ccs_pkg::CCS_STANDBY;
                end
            end
            default: next_state = ccs_pkg::CCS_SHUTDOWN;
        endcase
        if (!live) begin
            next_state = ccs_pkg::CCS_SHUTDOWN;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= ccs_pkg::CCS_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    logic charging;
    assign charging = (state == ccs_pkg::CCS_PRECOND) || (state == ccs_pkg::CCS_FAST) ||
                      (state == ccs_pkg::CCS_CV);

    ////////////////////////////////////////////////////////////////////////////////
    // Safety timer
    logic [ccs_pkg::TIMER_WIDTH-1:0] safety_cnt;
    logic entering_fast;
    assign entering_fast = (next_state == ccs_pkg::CCS_FAST) && (state != ccs_pkg::CCS_FAST);
    assign timer_expired = !tdis_s && (safety_cnt >= TIMER_TICKS);

    always_ff @(posedge core_clk) begin
        if (!nrst || !live) begin
            safety_cnt <= '0;
        end else if (entering_fast) begin
            safety_cnt <= '0;
        end else if (charging && tick && !suspend && safety_cnt < TIMER_TICKS) begin
            safety_cnt <= safety_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Termination filter
    logic [7:0] term_cnt;
    always_ff @(posedge core_clk) begin
        if (!nrst || state != ccs_pkg::CCS_CV || !term_s) begin
            term_cnt <= '0;
        end else if (tick && term_cnt < 8'(ccs_pkg::TERM_FILTER_TICKS)) begin
            term_cnt <= term_cnt + 8'h01;
        end
    end
    assign term_ok = term_s && (term_cnt >= 8'(ccs_pkg::TERM_FILTER_TICKS)) && !suspend;

    ////////////////////////////////////////////////////////////////////////////////
    // Charge drive
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            charge_on <= 1'b0;
            charge_level <= ccs_pkg::CUR_OFF;
            charge_reduce <= 1'b0;
        end else begin
            charge_on <= charging && !suspend && next_state == state;
            unique case (state)
                ccs_pkg::CCS_PRECOND: charge_level <= ccs_pkg::CUR_PRECOND;
                ccs_pkg::CCS_FAST: charge_level <= ccs_pkg::CUR_FAST;
                ccs_pkg::CCS_CV: charge_level <= ccs_pkg::CUR_CV;
                default: charge_level <= ccs_pkg::CUR_OFF;
            endcase
            charge_reduce <= charging && (icl_s || (vpc_s && !strap_s));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            regulation_voltage <= ccs_pkg::REGULATION_VOLTAGE_SEL_4V20;
        end else begin
            unique case (REGULATION_VOLTAGE_OPTION)
                ccs_pkg::REGULATION_VOLTAGE_CODE_4V10: regulation_voltage <= ccs_pkg::REGULATION_VOLTAGE_SEL_4V10;
                ccs_pkg::REGULATION_VOLTAGE_CODE_4V35: regulation_voltage <= ccs_pkg::REGULATION_VOLTAGE_SEL_4V35;
                ccs_pkg::REGULATION_VOLTAGE_CODE_4V40: regulation_voltage <= ccs_pkg::REGULATION_VOLTAGE_SEL_4V40;
                default: regulation_voltage <= ccs_pkg::REGULATION_VOLTAGE_SEL_4V20;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status pins: out is always 0, only enable moves
    logic a_low, b_low, g_low;
    always_comb begin
        a_low = 1'b0;
        b_low = 1'b0;
        g_low = uvlo_s & inabove_s;
        if (!uvlo_s || !inabove_s) begin
            a_low = low_s;
        end else if (!en_s) begin
            a_low = 1'b0;
        end else if (state == ccs_pkg::CCS_FAULT || (charging && temp_bad_s)) begin
            a_low = 1'b1;
            b_low = 1'b1;
        end else if (charging) begin
            a_low = 1'b1;
        end else if (state == ccs_pkg::CCS_COMPLETE ||
                     (state == ccs_pkg::CCS_STANDBY && bat_s)) begin
            b_low = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            status_line_a_oe <= 1'b0;
            status_line_b_oe <= 1'b0;
            input_good_n_oe <= 1'b0;
            timer_fault <= 1'b0;
            charge_state <= 3'h0;
        end else begin
            status_line_a_oe <= a_low;
            status_line_b_oe <= b_low;
            input_good_n_oe <= g_low;
            timer_fault <= (state == ccs_pkg::CCS_FAULT);
            charge_state <= state;
        end
    end

    always_ff @(posedge core_clk) begin
        status_line_a_out <= 1'b0;
        status_line_b_out <= 1'b0;
        input_good_n_out <= 1'b0;
    end
endmodule : ccs_sequencer

// ### sim/ccs_host_model.sv
// Host side: pulled-up status lines as read by LEDs or a controller
`timescale 1ns/1ps
module ccs_host_model (
    input wire logic status_line_a_out,
    input wire logic status_line_a_oe,
    input wire logic status_line_b_out,
    input wire logic status_line_b_oe,
    input wire logic input_good_n_out,
    input wire logic input_good_n_oe,
    output logic [2:0] pins
);
    ////////////////////////////////////////
    // Released line reads high through pull-up; a driven high shows up too
    assign pins = {status_line_a_oe ? status_line_a_out : 1'b1,
                   status_line_b_oe ? status_line_b_out : 1'b1,
                   input_good_n_oe ? input_good_n_out : 1'b1};
endmodule : ccs_host_model

// ### sim/ccs_seq_props.sv
// Checker: concurrent properties on the sequencer ports
`timescale 1ns/1ps
module ccs_seq_props #(
    parameter logic [2:0] REGULATION_VOLTAGE_OPTION = ccs_pkg::REGULATION_VOLTAGE_CODE_4V20
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic charge_enable,
    input wire logic uvlo_ok,
    input wire logic battery_temp_hot,
    input wire logic battery_temp_cold,
    input wire logic charge_on,
    input wire logic [1:0] charge_level,
    input wire logic [1:0] regulation_voltage,
    input wire logic timer_fault,
    input wire logic [2:0] charge_state,
    input wire logic status_line_a_out,
    input wire logic status_line_a_oe,
    input wire logic status_line_b_out,
    input wire logic status_line_b_oe,
    input wire logic input_good_n_out,
    input wire logic input_good_n_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    a_outs_never_high: assert property (!status_line_a_out && !status_line_b_out
        && !input_good_n_out) else $error("status output driven high");
    a_precond_tenth: assert property (charge_state == ccs_pkg::CCS_PRECOND && charge_on
        |-> charge_level == ccs_pkg::CUR_PRECOND) else $error("precondition level wrong");
    a_fault_pins: assert property (timer_fault
        |-> status_line_a_oe && status_line_b_oe && input_good_n_oe) else $error("fault pins");
    a_cv_entry: assert property ($changed(charge_state) && charge_state == ccs_pkg::CCS_CV
        |-> $past(charge_state) == ccs_pkg::CCS_FAST) else $error("CV not entered from fast");
    a_done_entry: assert property ($changed(charge_state)
        && charge_state == ccs_pkg::CCS_COMPLETE |-> $past(charge_state) == ccs_pkg::CCS_CV)
        else $error("complete not entered from CV");
    a_fault_entry: assert property ($changed(charge_state)
        && charge_state == ccs_pkg::CCS_FAULT |-> $past(charge_state) == ccs_pkg::CCS_FAST)
        else $error("fault not entered from fast");
    a_reg_select: assert property ($past(nrst, 2)
        |-> regulation_voltage == 2'(REGULATION_VOLTAGE_OPTION - 3'h1)) else $error("regulation select");
    a_uvlo_shutdown: assert property (!uvlo_ok [*6]
        |-> charge_state == ccs_pkg::CCS_SHUTDOWN && !charge_on) else $error("uvlo not off");
    a_enable_off: assert property (!charge_enable [*6] |-> !charge_on)
        else $error("charging while disabled");
    a_temp_off: assert property ((battery_temp_hot || battery_temp_cold) [*6]
        |-> !charge_on) else $error("charging with battery temp out of window");
    a_done_off: assert property (charge_state == ccs_pkg::CCS_COMPLETE
        && $past(charge_state) == ccs_pkg::CCS_COMPLETE |-> !charge_on) else $error("done on");
    c_cv: cover property (charge_state == ccs_pkg::CCS_CV);
    c_done: cover property (charge_state == ccs_pkg::CCS_COMPLETE);
    c_fault: cover property (timer_fault);
endmodule : ccs_seq_props

bind ccs_sequencer ccs_seq_props #(.REGULATION_VOLTAGE_OPTION(REGULATION_VOLTAGE_OPTION)) props_u (
    .core_clk(core_clk), .nrst(nrst), .charge_enable(charge_enable), .uvlo_ok(uvlo_ok),
    .battery_temp_hot(battery_temp_hot), .battery_temp_cold(battery_temp_cold),
    .charge_on(charge_on), .charge_level(charge_level), .regulation_voltage(regulation_voltage),
    .timer_fault(timer_fault), .charge_state(charge_state),
    .status_line_a_out(status_line_a_out), .status_line_a_oe(status_line_a_oe),
    .status_line_b_out(status_line_b_out), .status_line_b_oe(status_line_b_oe),
    .input_good_n_out(input_good_n_out), .input_good_n_oe(input_good_n_oe));

// ### sim/tb_top.sv
// Testbench: charge cycle sequencer scenarios
`timescale 1ns/1ps
module tb_top;
    // Pin patterns {a, b, good}: 0 pulled low, 1 released
    localparam logic [2:0] CHG = 3'h2, DONE = 3'h4, FLT = 3'h0, LOWB = 3'h3, OFF = 3'h6;
    localparam logic [2:0] NOIN = 3'h7;
    logic core_clk = 1'b0, nrst = 1'b0, charge_enable = 1'b0, timer_disable = 1'b0;
    logic uvlo_ok = 1'b0, input_above_battery = 1'b0, battery_present = 1'b0;
    logic battery_low = 1'b0, vbat_at_regulation = 1'b0, vbat_below_recharge = 1'b0;
    logic vbat_below_precond = 1'b0, termination_set = 1'b0, battery_temp_hot = 1'b0;
    logic battery_temp_cold = 1'b0, die_over_150c = 1'b0, die_below_140c = 1'b1;
    logic input_current_limit_ctrl = 1'b0, input_voltage_charge_ctrl = 1'b0;
    logic input_voltage_ctrl_strapped = 1'b0;
    logic charge_on, charge_reduce, timer_fault, a_out, a_oe, b_out, b_oe, g_out, g_oe;
    logic [1:0] charge_level, regulation_voltage;
    logic [2:0] charge_state, pins;
    int fail_count = 0;
    int tests_run = 0;
    always #10 core_clk = ~core_clk;
    // Short tick and timer: timer runs out after 250 clocks, filter after 50
    ccs_sequencer #(.TICK_CYCLES(5), .TIMER_TICKS(32'h32),
        .REGULATION_VOLTAGE_OPTION(ccs_pkg::REGULATION_VOLTAGE_CODE_4V35)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .charge_enable(charge_enable),
        .timer_disable(timer_disable), .uvlo_ok(uvlo_ok), .input_above_battery(input_above_battery),
        .battery_present(battery_present), .battery_low(battery_low),
        .vbat_at_regulation(vbat_at_regulation), .vbat_below_recharge(vbat_below_recharge),
        .vbat_below_precond(vbat_below_precond), .termination_set(termination_set),
        .battery_temp_hot(battery_temp_hot), .battery_temp_cold(battery_temp_cold),
        .die_over_150c(die_over_150c), .die_below_140c(die_below_140c),
        .input_current_limit_ctrl(input_current_limit_ctrl),
        .input_voltage_charge_ctrl(input_voltage_charge_ctrl),
        .input_voltage_ctrl_strapped(input_voltage_ctrl_strapped), .charge_on(charge_on),
        .charge_level(charge_level), .charge_reduce(charge_reduce),
        .regulation_voltage(regulation_voltage), .timer_fault(timer_fault),
        .charge_state(charge_state), .status_line_a_out(a_out), .status_line_a_oe(a_oe),
        .status_line_b_out(b_out), .status_line_b_oe(b_oe), .input_good_n_out(g_out),
        .input_good_n_oe(g_oe));
    ccs_host_model host_u (.status_line_a_out(a_out), .status_line_a_oe(a_oe),
        .status_line_b_out(b_out), .status_line_b_oe(b_oe), .input_good_n_out(g_out),
        .input_good_n_oe(g_oe), .pins(pins));
    ////////////////////////////////////////
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        #1;
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task wait_st(input logic [2:0] s, input int n);
        for (int i = 0; i < n && charge_state !== s; i++) @(posedge core_clk);
        check("charge_state", 8'(charge_state), 8'(s));
    endtask : wait_st
    // Reset, start below the precondition threshold, then move up to fast charge
    task start(input logic recharge);
        tick(1);
        {nrst, charge_enable, timer_disable, uvlo_ok, input_above_battery, battery_present,
            battery_low, vbat_at_regulation, vbat_below_recharge, vbat_below_precond,
            termination_set, battery_temp_hot, battery_temp_cold, die_over_150c, die_below_140c,
            input_current_limit_ctrl, input_voltage_charge_ctrl, input_voltage_ctrl_strapped}
            <= {6'h17, 2'h0, recharge, 9'h108};
        tick(3);
        nrst <= 1'b1;
        wait_st(ccs_pkg::CCS_PRECOND, 15);
        tick(2);
        check("charge_level", 8'(charge_level), 8'(ccs_pkg::CUR_PRECOND));
        check("pins", 8'(pins), 8'(CHG));
        tick(1);
        vbat_below_precond <= 1'b0;
        wait_st(ccs_pkg::CCS_FAST, 15);
    endtask : start
    ////////////////////////////////////////
    task t_full_cycle;
        start(1'b0);
        tick(2);
        check("charge_level", 8'(charge_level), 8'(ccs_pkg::CUR_FAST));
        tick(1);
        vbat_at_regulation <= 1'b1;
        wait_st(ccs_pkg::CCS_CV, 10);
        check("regulation_voltage", 8'(regulation_voltage), 8'(ccs_pkg::REGULATION_VOLTAGE_SEL_4V35));
        tick(1);
        termination_set <= 1'b1;
        tick(30);
        termination_set <= 1'b0;
        tick(10);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_CV));
        tick(1);
        termination_set <= 1'b1;
        tick(45);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_CV));
        wait_st(ccs_pkg::CCS_COMPLETE, 20);
        tick(2);
        check("charge_on", 8'(charge_on), 8'h00);
        check("pins", 8'(pins), 8'(DONE));
        tick(1);
        {vbat_at_regulation, termination_set, vbat_below_recharge} <= 3'h1;
        tick(20);
        check("charge_on", 8'(charge_on), 8'h01);
    endtask : t_full_cycle
    task t_timer;
        start(1'b1);
        tick(180);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_FAST));
        wait_st(ccs_pkg::CCS_FAULT, 150);
        tick(2);
        check("timer_fault", 8'(timer_fault), 8'h01);
        check("pins", 8'(pins), 8'(FLT));
        tick(1);
        battery_present <= 1'b0;
        wait_st(ccs_pkg::CCS_STANDBY, 10);
        tick(2);
        check("pins", 8'(pins), 8'(OFF));
        tick(1);
        battery_present <= 1'b1;
        wait_st(ccs_pkg::CCS_FAST, 20);
        tick(150);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_FAST));
        tick(1);
        timer_disable <= 1'b1;
        tick(300);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_FAST));
    endtask : t_timer
    task t_suspend;
        start(1'b1);
        tick(1);
        {die_over_150c, die_below_140c} <= 2'h2;
        tick(6);
        check("charge_on", 8'(charge_on), 8'h00);
        tick(1);
        die_over_150c <= 1'b0;
        tick(20);
        check("charge_on", 8'(charge_on), 8'h00);
        tick(1);
        die_below_140c <= 1'b1;
        tick(8);
        check("charge_on", 8'(charge_on), 8'h01);
        tick(1);
        battery_temp_hot <= 1'b1;
        tick(6);
        check("charge_on", 8'(charge_on), 8'h00);
        check("pins", 8'(pins), 8'(FLT));
        tick(300);
        {battery_temp_hot, battery_temp_cold} <= 2'h1;
        tick(6);
        check("charge_on", 8'(charge_on), 8'h00);
        tick(1);
        battery_temp_cold <= 1'b0;
        tick(150);
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_FAST));
        check("charge_on", 8'(charge_on), 8'h01);
        wait_st(ccs_pkg::CCS_FAULT, 100);
    endtask : t_suspend
    task t_reduce_and_off;
        start(1'b0);
        check("charge_reduce", 8'(charge_reduce), 8'h00);
        tick(1);
        input_current_limit_ctrl <= 1'b1;
        tick(6);
        check("charge_reduce", 8'(charge_reduce), 8'h01);
        tick(1);
        {input_current_limit_ctrl, input_voltage_charge_ctrl} <= 2'h1;
        tick(6);
        check("charge_reduce", 8'(charge_reduce), 8'h01);
        tick(1);
        input_voltage_ctrl_strapped <= 1'b1;
        tick(6);
        check("charge_reduce", 8'(charge_reduce), 8'h00);
        tick(1);
        charge_enable <= 1'b0;
        wait_st(ccs_pkg::CCS_SHUTDOWN, 10);
        tick(2);
        check("pins", 8'(pins), 8'(OFF));
        tick(1);
        {charge_enable, uvlo_ok, input_above_battery, battery_low} <= 4'h9;
        tick(8);
        check("pins", 8'(pins), 8'(LOWB));
        check("charge_state", 8'(charge_state), 8'(ccs_pkg::CCS_SHUTDOWN));
        tick(1);
        battery_low <= 1'b0;
        tick(6);
        check("pins", 8'(pins), 8'(NOIN));
    endtask : t_reduce_and_off
    task final_report;
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial begin
        t_full_cycle;
        t_timer;
        t_suspend;
        t_reduce_and_off;
        final_report;
    end
    // Scenarios need about 1600 clocks; a hang is cut at 20000
    initial begin
        // Own wait, so the shared static task is never entered twice at once
        repeat (20000) @(posedge core_clk);
        fail_count++;
        final_report;
    end
endmodule : tb_top
